/* strobe_pkg.sv */
// Purpose: constants for the camera flash-strobe controller
// Assumes: 16-bit registers on a plain register port, byte addressed
// Notes: offsets are the byte addresses of the 16-bit registers
package strobe_pkg;
	localparam logic [15:0] OFS_LINE_DELAY = 16'h2020;
	localparam logic [15:0] OFS_PULSE_WIDTH = 16'h2022;
	localparam logic [15:0] OFS_STROBE_SETTING = 16'h2024;
	localparam logic [15:0] OFS_CAPTURE_CMD = 16'h2030;
	localparam logic [15:0] OFS_PIN_MUX = 16'h2032;
	localparam logic [15:0] OFS_IRQ_STATUS = 16'h2034;
	localparam logic [15:0] OFS_IRQ_MASK = 16'h2036;
	localparam logic [15:0] OFS_CAPTURE_STATUS = 16'h2038;
	localparam int BIT_PORT_EN = 0;
	localparam int BIT_ACTIVE_HIGH = 1;
	localparam int BIT_DELAY_LO = 4;
	localparam int BIT_CAM_EN = 11;
	localparam int BIT_REQ_FLAG = 15;
	localparam logic [15:0] SETTING_WRITE_MASK = 16'h08F3;
	localparam logic [15:0] RESET_VALUE = 16'h0000;
	localparam int BIT_CMD_STOP = 2;
	localparam int BIT_CMD_START = 3;
	localparam int BIT_CMD_SINGLE = 6;
	localparam int MUX_HI = 15;
	localparam int MUX_LO = 14;
	localparam logic [1:0] MUX_STROBE = 2'h3;
	localparam int REQ_CYCLES = 4;
	localparam int IRQ_BITS = 3;
	localparam int IRQ_REQ = 0;
	localparam int IRQ_PULSE_DONE = 1;
	localparam int IRQ_CAPTURE = 2;
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_WAIT = 2'b01,
		ST_PULSE = 2'b10,
		ST_HOLD = 2'b11
	} strobe_state_t;
endpackage

/* sync2.sv */
// Purpose: two-flop synchroniser for one level
// Assumes: input is asynchronous to clk_sys
// Notes: first stage is read only by the second
`timescale 1ns/100ps
`default_nettype none
module sync2 (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst_b,
	// level
	input wire logic async_in,
	output logic sync_out
);
	logic meta_q;
	logic meta_d;
	logic sync_q;
	logic sync_d;

	always_comb begin
		meta_d = async_in;
		sync_d = meta_q;
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			meta_q <= 1'b0;
			sync_q <= 1'b0;
		end else begin
			meta_q <= meta_d;
			sync_q <= sync_d;
		end
	end

	assign sync_out = sync_q;
endmodule // sync2
`default_nettype wire

/* edge_find.sv */
// Purpose: rise and fall pulses of a synchronised level
// Assumes: input already in the clk_sys domain
// Notes: one-cycle pulses
`timescale 1ns/100ps
`default_nettype none
module edge_find (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst_b,
	// level and edges
	input wire logic level_in,
	output logic rise,
	output logic fall
);
	logic prev_q;
	logic prev_d;

	always_comb begin
		prev_d = level_in;
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			prev_q <= 1'b0;
		end else begin
			prev_q <= prev_d;
		end
	end

	assign rise = level_in & ~prev_q;
	assign fall = ~level_in & prev_q;
endmodule // edge_find
`default_nettype wire

/* camera_strobe_control.sv */
// Purpose: camera flash strobe controller with frame capture delay
// Assumes: camera pins sampled by clk_sys; camera clock far slower
// Notes: frame capture ready pulse marks the frame the capture path should keep
`timescale 1ns/100ps
`default_nettype none
module camera_strobe_control
	import strobe_pkg::*;
#(
	parameter int REQ_LEN = REQ_CYCLES
) (
	// system
	input wire logic clk_sys,
	input wire logic rst_b,
	// register port
	input wire logic [15:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [15:0] reg_rdata,
	// camera
	input wire logic cam_pixel_clock,
	input wire logic cam_line_reference,
	input wire logic cam_frame_reference,
	// flash pin
	output logic shared_port_b_pin7,
	output logic shared_port_b_pin7_oe,
	// capture path and interrupt
	output logic capture_frame,
	output logic irq
);
	// ****************************************
	// input synchronisation and edges
	// ****************************************
	logic pclk_s, href_s, vref_s;
	logic pclk_rise, href_fall, vref_rise, vref_fall;
	logic unused_pclk_fall, unused_href_rise;

	sync2 u_sync_pclk (.clk_sys(clk_sys), .rst_b(rst_b), .async_in(cam_pixel_clock),
		.sync_out(pclk_s));
	sync2 u_sync_href (.clk_sys(clk_sys), .rst_b(rst_b), .async_in(cam_line_reference),
		.sync_out(href_s));
	sync2 u_sync_vref (.clk_sys(clk_sys), .rst_b(rst_b), .async_in(cam_frame_reference),
		.sync_out(vref_s));
	edge_find u_edge_pclk (.clk_sys(clk_sys), .rst_b(rst_b), .level_in(pclk_s),
		.rise(pclk_rise), .fall(unused_pclk_fall));
	edge_find u_edge_href (.clk_sys(clk_sys), .rst_b(rst_b), .level_in(href_s),
		.rise(unused_href_rise), .fall(href_fall));
	edge_find u_edge_vref (.clk_sys(clk_sys), .rst_b(rst_b), .level_in(vref_s),
		.rise(vref_rise), .fall(vref_fall));

	// ****************************************
	// registers
	// ****************************************
	logic [15:0] line_delay_q, line_delay_d;
	logic [15:0] pulse_width_q, pulse_width_d;
	logic [15:0] setting_q, setting_d;
	logic [15:0] pin_mux_q, pin_mux_d;
	logic single_mode_q, single_mode_d;
	logic req_flag_q, req_flag_d;
	logic [IRQ_BITS-1:0] irq_stat_q, irq_stat_d;
	logic [IRQ_BITS-1:0] irq_mask_q, irq_mask_d;
	logic [15:0] rdata_q, rdata_d;
	logic cmd_stop, cmd_start;
	logic cam_req;
	logic pulse_done;

	logic port_en, active_high, cam_en, pin_sel;
	logic [3:0] frame_delay;
	assign port_en = setting_q[BIT_PORT_EN];
	assign active_high = setting_q[BIT_ACTIVE_HIGH];
	assign cam_en = setting_q[BIT_CAM_EN];
	assign pin_sel = (pin_mux_q[MUX_HI:MUX_LO] == MUX_STROBE);
	// single mode forces zero frames of delay
	assign frame_delay = single_mode_q ? 4'h0 : setting_q[BIT_DELAY_LO +: 4];

	logic wr_cmd;
	assign wr_cmd = reg_wr && (reg_addr == OFS_CAPTURE_CMD);
	assign cmd_stop = wr_cmd && reg_wdata[BIT_CMD_STOP];
	assign cmd_start = wr_cmd && reg_wdata[BIT_CMD_START];

	always_comb begin
		line_delay_d = line_delay_q;
		pulse_width_d = pulse_width_q;
		setting_d = setting_q;
		pin_mux_d = pin_mux_q;
		single_mode_d = single_mode_q;
		irq_mask_d = irq_mask_q;
		irq_stat_d = irq_stat_q;
		rdata_d = 16'h0000;
		if (reg_wr) begin
			if (reg_addr == OFS_LINE_DELAY) begin
				line_delay_d = reg_wdata;
			end else if (reg_addr == OFS_PULSE_WIDTH) begin
				pulse_width_d = reg_wdata;
			end else if (reg_addr == OFS_STROBE_SETTING) begin
				// reserved bits and the flag are not writable
				setting_d = reg_wdata & SETTING_WRITE_MASK;
			end else if (reg_addr == OFS_PIN_MUX) begin
				pin_mux_d = reg_wdata;
			end else if (reg_addr == OFS_CAPTURE_CMD) begin
				single_mode_d = reg_wdata[BIT_CMD_SINGLE];
			end else if (reg_addr == OFS_IRQ_STATUS) begin
				irq_stat_d = irq_stat_q & ~reg_wdata[IRQ_BITS-1:0];
			end else if (reg_addr == OFS_IRQ_MASK) begin
				irq_mask_d = reg_wdata[IRQ_BITS-1:0];
			end
		end
		// set after clear so a simultaneous event wins
		if (cam_req) begin
			irq_stat_d[IRQ_REQ] = 1'b1;
		end
		if (pulse_done) begin
			irq_stat_d[IRQ_PULSE_DONE] = 1'b1;
		end
		if (capture_frame) begin
			irq_stat_d[IRQ_CAPTURE] = 1'b1;
		end
		if (reg_rd) begin
			if (reg_addr == OFS_LINE_DELAY) begin
				rdata_d = line_delay_q;
			end else if (reg_addr == OFS_PULSE_WIDTH) begin
				rdata_d = pulse_width_q;
			end else if (reg_addr == OFS_STROBE_SETTING) begin
				rdata_d = setting_q;
				rdata_d[BIT_REQ_FLAG] = req_flag_q;
			end else if (reg_addr == OFS_PIN_MUX) begin
				rdata_d = pin_mux_q;
			end else if (reg_addr == OFS_CAPTURE_CMD) begin
				rdata_d[BIT_CMD_SINGLE] = single_mode_q;
			end else if (reg_addr == OFS_IRQ_STATUS) begin
				rdata_d[IRQ_BITS-1:0] = irq_stat_q;
			end else if (reg_addr == OFS_IRQ_MASK) begin
				rdata_d[IRQ_BITS-1:0] = irq_mask_q;
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			line_delay_q <= RESET_VALUE;
			pulse_width_q <= RESET_VALUE;
			setting_q <= RESET_VALUE;
			pin_mux_q <= RESET_VALUE;
			single_mode_q <= 1'b0;
			irq_stat_q <= '0;
			irq_mask_q <= '0;
			rdata_q <= 16'h0000;
		end else begin
			line_delay_q <= line_delay_d;
			pulse_width_q <= pulse_width_d;
			setting_q <= setting_d;
			pin_mux_q <= pin_mux_d;
			single_mode_q <= single_mode_d;
			irq_stat_q <= irq_stat_d;
			irq_mask_q <= irq_mask_d;
			rdata_q <= rdata_d;
		end
	end

	assign reg_rdata = rdata_q;
	assign irq = |(irq_stat_q & irq_mask_q);

	// ****************************************
	// camera strobe request detection
	// ****************************************
	logic [2:0] req_cnt_q, req_cnt_d;
	logic req_cond;
	// line high and frame low counted in camera clock periods
	assign req_cond = href_s && !vref_s;
	assign cam_req = pclk_rise && req_cond && (req_cnt_q == 3'(REQ_LEN - 1));

	always_comb begin
		req_cnt_d = req_cnt_q;
		req_flag_d = req_flag_q;
		if (!req_cond) begin
			req_cnt_d = 3'h0;
		end else if (pclk_rise && req_cnt_q < 3'(REQ_LEN)) begin
			req_cnt_d = req_cnt_q + 3'h1;
		end
		if (vref_fall) begin
			req_flag_d = 1'b0;
		end
		if (cam_req) begin
			req_flag_d = 1'b1;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			req_cnt_q <= 3'h0;
			req_flag_q <= 1'b0;
		end else begin
			req_cnt_q <= req_cnt_d;
			req_flag_q <= req_flag_d;
		end
	end

	// ****************************************
	// strobe timing
	// ****************************************
	strobe_state_t state_q, state_d;
	logic [16:0] line_cnt_q, line_cnt_d;
	logic [3:0] frm_cnt_q, frm_cnt_d;
	logic pending_q, pending_d;
	logic trigger;
	logic strobe_active;

	assign trigger = port_en && ((single_mode_q && cmd_start)
		|| (!single_mode_q && cmd_stop)
		|| (cam_en && cam_req));

	always_comb begin
		state_d = state_q;
		line_cnt_d = line_cnt_q;
		frm_cnt_d = frm_cnt_q;
		pending_d = pending_q || trigger;
		pulse_done = 1'b0;
		capture_frame = 1'b0;
		case (state_q)
			ST_IDLE: begin
				// pulse is framed against the next frame start
				if (pending_q && vref_rise) begin
					state_d = ST_WAIT;
					pending_d = trigger;
					line_cnt_d = 17'h00000;
				end
			end
			ST_WAIT: begin
				if (href_fall) begin
					if (line_cnt_q == {1'b0, line_delay_q}) begin
						state_d = ST_PULSE;
						line_cnt_d = 17'h00000;
					end else begin
						line_cnt_d = line_cnt_q + 17'h00001;
					end
				end
			end
			ST_PULSE: begin
				if (href_fall) begin
					if (line_cnt_q == {1'b0, pulse_width_q}) begin
						state_d = ST_HOLD;
						pulse_done = 1'b1;
						frm_cnt_d = frame_delay;
					end else begin
						line_cnt_d = line_cnt_q + 17'h00001;
					end
				end
			end
			ST_HOLD: begin
				if (frm_cnt_q == 4'h0) begin
					capture_frame = 1'b1;
					state_d = ST_IDLE;
				end else if (vref_fall) begin
					frm_cnt_d = frm_cnt_q - 4'h1;
				end
			end
			default: begin
				state_d = ST_IDLE;
			end
		endcase
		if (!port_en) begin
			state_d = ST_IDLE;
			pending_d = 1'b0;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			state_q <= ST_IDLE;
			line_cnt_q <= 17'h00000;
			frm_cnt_q <= 4'h0;
			pending_q <= 1'b0;
		end else begin
			state_q <= state_d;
			line_cnt_q <= line_cnt_d;
			frm_cnt_q <= frm_cnt_d;
			pending_q <= pending_d;
		end
	end

	// ****************************************
	// pin drive
	// ****************************************
	logic pin_q, pin_d, oe_q, oe_d;
	assign strobe_active = (state_q == ST_PULSE) && port_en;

	always_comb begin
		// inactive level follows polarity even while idle
		pin_d = strobe_active ? active_high : !active_high;
		oe_d = pin_sel && port_en;
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			pin_q <= 1'b1;
			oe_q <= 1'b0;
		end else begin
			pin_q <= pin_d;
			oe_q <= oe_d;
		end
	end

	assign shared_port_b_pin7 = pin_q;
	assign shared_port_b_pin7_oe = oe_q;
endmodule // camera_strobe_control
`default_nettype wire

/* strobe_monitor.sv */
// Purpose: port checker for the camera strobe controller
// Assumes: sees only the top module ports
// Notes: bound into every instance of the controller
`timescale 1ns/100ps
`default_nettype none
module strobe_monitor
	import strobe_pkg::*;
#(
	parameter int REQ_LEN = REQ_CYCLES
) (
	// system and register port
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire logic [15:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [15:0] reg_rdata,
	// camera, pin and outputs
	input wire logic cam_line_reference,
	input wire logic cam_frame_reference,
	input wire logic shared_port_b_pin7,
	input wire logic shared_port_b_pin7_oe,
	input wire logic capture_frame,
	input wire logic irq
);
	// ****************************************
	// cycles since any sync edge or write
	// ****************************************
	logic [3:0] calm_q;
	logic [3:0] calm_d;
	logic line_q;
	logic frame_q;
	always_comb begin
		calm_d = calm_q + {3'h0, calm_q != 4'hF};
		if (!rst_b || reg_wr || line_q != cam_line_reference || frame_q != cam_frame_reference) begin
			calm_d = 4'h0;
		end
	end
	always_ff @(posedge clk_sys) begin
		calm_q <= calm_d;
		line_q <= cam_line_reference;
		frame_q <= cam_frame_reference;
	end
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_b);
	a_rdata_quiet: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
		else $error("read data not zero outside a read");
	a_unmapped_zero: assert property (reg_rd && reg_addr == 16'h2028 |=>
		reg_rdata == 16'h0000)
		else $error("unmapped read not zero");
	a_reserved_zero: assert property (reg_rd && reg_addr == OFS_STROBE_SETTING |=>
		reg_rdata[3:2] == 2'b00)
		else $error("reserved setting bits not zero");
	a_setting_back: assert property (
		(reg_wr && reg_addr == OFS_STROBE_SETTING) ##2 (reg_rd && reg_addr == OFS_STROBE_SETTING)
		|=> reg_rdata[11:0] == ($past(reg_wdata, 3) & 12'h8F3))
		else $error("setting read back wrong");
	// pin moves only shortly after a line edge or a write
	a_pin_cause: assert property ($changed(shared_port_b_pin7) |-> calm_q < 4'hC)
		else $error("strobe pin moved without cause");
	a_oe_by_write: assert property ($changed(shared_port_b_pin7_oe) |->
		$past(reg_wr) || $past(reg_wr, 2) || $past(reg_wr, 3))
		else $error("pin enable moved without a write");
	a_capture_single: assert property (capture_frame |=> !capture_frame)
		else $error("capture pulse longer than one cycle");
	a_irq_drop: assert property ($fell(irq) |-> $past(reg_wr) || $past(reg_wr, 2))
		else $error("interrupt fell without a write");
	cover property (capture_frame);
	cover property ($rose(irq));
	cover property ($changed(shared_port_b_pin7) && shared_port_b_pin7_oe);
endmodule // strobe_monitor
bind camera_strobe_control strobe_monitor #(.REQ_LEN(REQ_LEN)) u_mon (
	.clk_sys(clk_sys), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
	.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
	.cam_line_reference(cam_line_reference), .cam_frame_reference(cam_frame_reference),
	.shared_port_b_pin7(shared_port_b_pin7), .shared_port_b_pin7_oe(shared_port_b_pin7_oe),
	.capture_frame(capture_frame), .irq(irq));
`default_nettype wire

/* cam_model.sv */
// Purpose: camera sensor and flash unit beside the strobe controller
// Assumes: camera clock period 80 ns, six lines a frame
// Notes: flash counts line falls seen while lit
`timescale 1ns/100ps
`default_nettype none
module cam_model (
	// camera lines
	output logic cam_pixel_clock,
	output logic cam_line_reference,
	output logic cam_frame_reference,
	// flash pin
	input wire logic strobe_pin,
	input wire logic strobe_oe,
	input wire logic active_high
);
	int n_frames;
	int lit_first;
	int lit_lines;
	initial begin
		cam_pixel_clock = 1'b0;
		cam_line_reference = 1'b0;
		cam_frame_reference = 1'b0;
		n_frames = 0;
	end
	// the camera clock stands still while the sensor is idle
	// nonblocking, so lines that move on a system clock edge never race the sync flops
	task automatic tick(input int n);
		repeat (n) begin
			#40 cam_pixel_clock <= 1'b1;
			#40 cam_pixel_clock <= 1'b0;
		end
	endtask
	task automatic clear();
		lit_first = -1;
		lit_lines = 0;
	endtask
	task automatic request(input int n);
		cam_line_reference <= 1'b1;
		tick(n);
		cam_line_reference <= 1'b0;
		tick(2);
	endtask
	task automatic frame(input int lines);
		cam_frame_reference <= 1'b1;
		tick(2);
		for (int i = 0; i < lines; i++) begin
			cam_line_reference <= 1'b1;
			tick(3);
			cam_line_reference <= 1'b0;
			if (strobe_oe === 1'b1 && strobe_pin === active_high) begin
				if (lit_first < 0) lit_first = i;
				lit_lines++;
			end
			tick(3);
		end
		cam_frame_reference <= 1'b0;
		n_frames++;
		tick(4);
	endtask
endmodule // cam_model
`default_nettype wire

/* camera_strobe_control_bench.sv */
// Purpose: self-checking bench for the camera strobe controller
// Assumes: line delay 1 and pulse width 2 give lit falls 2 to 4
// Notes: capture frame index is counted from the strobe frame
`timescale 1ns/100ps
`default_nettype none
module camera_strobe_control_bench;
	import strobe_pkg::*;
	logic clk_sys, rst_b, reg_wr, reg_rd, pclk, lref, fref, pin, oe, cap, irq, pol;
	logic [15:0] reg_addr, reg_wdata, reg_rdata, v;
	int n_mismatch, tests_run, cap_at, base;
	camera_strobe_control DUT (.clk_sys(clk_sys), .rst_b(rst_b), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.cam_pixel_clock(pclk), .cam_line_reference(lref), .cam_frame_reference(fref),
		.shared_port_b_pin7(pin), .shared_port_b_pin7_oe(oe), .capture_frame(cap), .irq(irq));
	cam_model u_cam (.cam_pixel_clock(pclk), .cam_line_reference(lref),
		.cam_frame_reference(fref), .strobe_pin(pin), .strobe_oe(oe), .active_high(pol));
	initial begin
		clk_sys = 1'b0;
		forever #2 clk_sys = ~clk_sys;
	end
	always @(posedge clk_sys) begin
		if (cap === 1'b1) cap_at = u_cam.n_frames - base;
	end
	// ****************************************
	// bus cycles and compare
	// ****************************************
	task automatic wr(input logic [15:0] a, input logic [15:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
		@(posedge clk_sys);
	endtask
	task automatic rd(input logic [15:0] a);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1 v = reg_rdata;
		@(posedge clk_sys);
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		tests_run++;
		if (got !== exp) begin
			n_mismatch++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic fire(input logic [15:0] set, input logic [15:0] cmd, input int nfr);
		pol = set[1];
		wr(OFS_STROBE_SETTING, set);
		wr(OFS_CAPTURE_CMD, cmd);
		base = u_cam.n_frames;
		cap_at = -1;
		u_cam.clear();
		repeat (nfr) u_cam.frame(6);
		@(posedge clk_sys);
	endtask
	// ****************************************
	// scenarios
	// ****************************************
	task automatic t_regs();
		rd(OFS_STROBE_SETTING);
		chk(v, 16'h0000);
		chk({15'h0, pin}, 16'h0001);
		chk({15'h0, oe}, 16'h0000);
		wr(OFS_STROBE_SETTING, 16'hFFFF);
		rd(OFS_STROBE_SETTING);
		chk(v, 16'h08F3);
		rd(16'h2028);
		chk(v, 16'h0000);
		$display("done registers");
	endtask
	task automatic t_stop();
		wr(OFS_PIN_MUX, 16'hC000);
		wr(OFS_LINE_DELAY, 16'h0001);
		wr(OFS_PULSE_WIDTH, 16'h0002);
		wr(OFS_STROBE_SETTING, 16'h0003);
		// the pin registers land one cycle after the setting register
		@(posedge clk_sys);
		chk({15'h0, oe}, 16'h0001);
		chk({15'h0, pin}, 16'h0000);
		fire(16'h0003, 16'h0004, 1);
		chk(16'(u_cam.lit_first), 16'h0002);
		chk(16'(u_cam.lit_lines), 16'h0003);
		chk(16'(cap_at), 16'h0000);
		fire(16'h0002, 16'h0004, 1);
		chk(16'(u_cam.lit_lines), 16'h0000);
		chk({15'h0, pin}, 16'h0000);
		$display("done stop trigger");
	endtask
	task automatic t_delay();
		fire(16'h0023, 16'h0004, 4);
		chk(16'(cap_at), 16'h0002);
		fire(16'h00F3, 16'h0004, 17);
		chk(16'(cap_at), 16'h000F);
		$display("done frame delay");
	endtask
	task automatic t_single();
		wr(OFS_CAPTURE_CMD, 16'h0040);
		fire(16'h00F1, 16'h0048, 2);
		chk(16'(u_cam.lit_lines), 16'h0003);
		chk(16'(cap_at), 16'h0000);
		chk({15'h0, pin}, 16'h0001);
		$display("done single frame");
	endtask
	task automatic t_camera();
		wr(OFS_IRQ_MASK, 16'h0001);
		wr(OFS_STROBE_SETTING, 16'h0803);
		u_cam.request(3);
		rd(OFS_STROBE_SETTING);
		chk(v & 16'h8000, 16'h0000);
		u_cam.request(4);
		@(posedge clk_sys);
		rd(OFS_STROBE_SETTING);
		chk(v & 16'h8000, 16'h8000);
		chk({15'h0, irq}, 16'h0001);
		fire(16'h0803, 16'h0000, 1);
		chk(16'(u_cam.lit_lines), 16'h0003);
		rd(OFS_STROBE_SETTING);
		chk(v & 16'h8000, 16'h0000);
		// request, pulse done and capture have all been seen by now
		rd(OFS_IRQ_STATUS);
		chk(v, 16'h0007);
		wr(OFS_IRQ_STATUS, 16'h0007);
		chk({15'h0, irq}, 16'h0000);
		rd(OFS_IRQ_STATUS);
		chk(v, 16'h0000);
		// camera enable off before the request: flag still records it, no pulse
		wr(OFS_STROBE_SETTING, 16'h0003);
		u_cam.request(4);
		@(posedge clk_sys);
		rd(OFS_STROBE_SETTING);
		chk(v, 16'h8003);
		fire(16'h0003, 16'h0000, 1);
		chk(16'(u_cam.lit_lines), 16'h0000);
		$display("done camera request");
	endtask
	task automatic tally_and_finish();
		$display("compares %0d mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	initial begin
		rst_b = 1'b0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 16'h0000;
		reg_wdata = 16'h0000;
		pol = 1'b0;
		n_mismatch = 0;
		tests_run = 0;
		cap_at = -1;
		base = 0;
		repeat (2) @(posedge clk_sys);
		rst_b <= 1'b1;
		@(posedge clk_sys);
		t_regs();
		t_stop();
		t_delay();
		t_single();
		t_camera();
		tally_and_finish();
	end
	// about thirty frames of 3.4 us each are expected; allow three times that
	initial begin
		#300000;
		n_mismatch++;
		tally_and_finish();
	end
endmodule // camera_strobe_control_bench
`default_nettype wire
